// >>> verilog/ata_status_consts.svh
// Register selects, bit positions and codes of the status reporting block
`ifndef ATA_STATUS_CONSTS_SVH
`define ATA_STATUS_CONSTS_SVH
// Register selects on the shadow register port
`define SEL_ERROR 3'h1
`define SEL_SECTOR 3'h3
`define SEL_ALT_STATUS 3'h6
`define SEL_STATUS 3'h7
// Status register bit positions
`define ST_BUSY 7
`define ST_READY 6
`define ST_FAULT 5
`define ST_SEEK 4
`define ST_XFER 3
`define ST_FIXED 2
`define ST_INDEX 1
`define ST_FAIL 0
// Error byte bits that are reported; the others always read zero
`define ERR_ZERO_MASK 8'hd7
// Alignment error reporting field codes that enable reporting
`define ALIGN_RPT_A 2'h1
`define ALIGN_RPT_B 2'h2
// Opcode of the extended request-sense command
`define OP_SENSE_EXT 8'h0b
`define BYTE_ZERO 8'h00
// Address bytes reloaded into the starting-sector register
`define LBA_BYTE0 7:0
`define LBA_BYTE3 31:24
`define COUNT_ZERO 16'h0000
`endif

// >>> verilog/ata_status_pkg.sv
// Types shared by the status reporting block
package ata_status_pkg;
  // One register access from the shadow register link
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] sel;
    logic hob;
    logic [7:0] wdata;
  } host_access_t;
  // Outcome of a command, presented by the command engine
  typedef struct packed {
    logic done;
    logic [7:0] err_bits;
    logic write_cmd;
    logic misaligned;
    logic stream_cmd;
    logic continuous;
    logic is_48bit;
    logic sense_data;
    logic [47:0] cur_lba;
    logic [47:0] first_bad_lba;
    logic [15:0] bad_count;
  } completion_t;
  // Identify-data support and enable bits
  typedef struct packed {
    logic lps_sup;
    logic misalign_sup;
    logic [1:0] align_rpt;
    logic sense_sup;
    logic sense_en;
    logic fault_sense_sup;
  } feature_t;
  // Normal and error output fields returned at completion
  typedef struct packed {
    logic [7:0] status_field;
    logic [7:0] error_field;
    logic [47:0] lba_field;
    logic [15:0] count_field;
  } output_fields_t;
endpackage

// >>> verilog/ata_status_reporting.sv
// Starting-sector register, status register and output field generation
`timescale 1ns/100ps
`default_nettype none
`include "ata_status_consts.svh"

// Contract
// - At command end the sector register takes current address bits 0-7.
// - 48-bit commands keep two bytes: newest bits 0-7, previous 24-31.
// - Status bit layout fixed; refreshed on any error and each completion.
// - Status read while interrupt pending acknowledges and clears it; a status read while busy leaves it set.
// - While busy, any register read returns the status register.
// - Ready low at power-on until able; low after error until status read.
// - Fault and fixed-data status bits always read zero.
// - Seek flag cleared at seek start, set on settle, frozen after error.
// - Index pulse asserted briefly once per revolution.
// - Failed flag set on command error, cleared when next command arrives.
// - STATUS field layout: busy, ready, fault/stream, request, align, sense, err.
// - Alignment error only with support bits, code 01/10, clean misaligned write.
// - Alignment error hidden by other write errors; misalignment still logged.
// - Stream error set on error in continuous stream command, else clear.
// - With stream error, LBA field gives first bad sector, COUNT the run.
// - Continuous stream errors set stream error, clear error bit, log info.
// - Under fault, every command aborts with fault bit except sense ext.
// - Sense ext under fault completes with hardware sense if supported.
// - Fault bit clears only at power cycle.
// - STATUS error bit is the OR of the ERROR field bits, except on stream error.
// - ERROR byte layout fixed; bits 5 and 3 read zero.
module ata_status_reporting (
  input wire logic clk,
  input wire logic reset,
  input wire ata_status_pkg::host_access_t host_acc,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic cmd_written,
  output logic [7:0] cmd_opcode,
  input wire logic busy_in,
  input wire logic xfer_req_in,
  input wire logic power_ready,
  input wire logic cmd_error,
  input wire ata_status_pkg::completion_t compl,
  input wire ata_status_pkg::feature_t feat,
  input wire logic seek_start,
  input wire logic seek_settled,
  input wire logic low_power_mode,
  input wire logic index_sense,
  input wire logic fault_detect,
  input wire logic misalign_log_space,
  output ata_status_pkg::output_fields_t out_fields,
  output logic intr_pending,
  output logic misalign_log_wr,
  output logic stream_log_wr,
  output logic stream_log_is_write,
  output logic fault_abort,
  output logic sense_hw_error
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic [7:0] sect_cur_reg;
  logic [7:0] sect_prev_reg;
  logic ready_reg;
  logic err_hold_reg;
  logic seek_live_reg;
  logic seek_shown_reg;
  logic fail_reg;
  logic intr_reg;
  logic fault_reg;
  logic [7:0] err_byte_reg;
  logic idx_meta_reg;
  logic idx_sync_reg;
  logic idx_prev_reg;
  logic [7:0] rd_data_reg;
  logic rd_valid_reg;
  logic cmd_wr_reg;
  logic [7:0] opcode_reg;
  logic fault_abort_reg;
  logic sense_hw_reg;
  logic mis_log_reg;
  logic stream_log_reg;
  logic stream_dir_reg;
  ata_status_pkg::output_fields_t fields_reg;

  // ************************************************************
  // Access decode
  // ************************************************************
  // Writing the status select is a command write
  wire status_sel = host_acc.sel == `SEL_STATUS;
  wire sector_sel = host_acc.sel == `SEL_SECTOR;
  wire status_rd = host_acc.rd && status_sel && !busy_in;
  wire busy_rd = host_acc.rd && busy_in;
  wire ack_rd = status_rd || busy_rd;
  wire cmd_wr = host_acc.wr && status_sel && !busy_in;
  wire sect_wr = host_acc.wr && sector_sel && !busy_in;
  // Command errors come from the engine or from completion error bits
  wire any_err = cmd_error || (compl.done && (compl.err_bits != `BYTE_ZERO));
  wire index_pulse = idx_sync_reg && !idx_prev_reg;

  // ************************************************************
  // Status register image
  // ************************************************************
  // Busy, request and index are live; the rest is latched state
  wire [7:0] status_img = {busy_in,
                           ready_reg,
                           1'b0,
                           seek_shown_reg,
                           xfer_req_in,
                           1'b0,
                           index_pulse,
                           fail_reg};
  // Masked error byte; bits 5 and 3 never reported
  wire [7:0] err_masked = compl.err_bits & `ERR_ZERO_MASK;

  // Read mux; a busy device answers every select with status
  wire [7:0] sect_rd = host_acc.hob ? sect_prev_reg : sect_cur_reg;
  wire [7:0] rd_mux = busy_in ? status_img :
                      (host_acc.sel == `SEL_STATUS) ? status_img :
                      (host_acc.sel == `SEL_ALT_STATUS) ? status_img :
                      (host_acc.sel == `SEL_ERROR) ? err_byte_reg :
                      (host_acc.sel == `SEL_SECTOR) ? sect_rd :
                      `BYTE_ZERO;

  // ************************************************************
  // Output field generation
  // ************************************************************
  wire rpt_on = (feat.align_rpt == `ALIGN_RPT_A) ||
                (feat.align_rpt == `ALIGN_RPT_B);
  // Alignment only on a clean misaligned write; other errors win
  wire align_err = feat.lps_sup && feat.misalign_sup && rpt_on &&
                   compl.write_cmd && compl.misaligned &&
                   (err_masked == `BYTE_ZERO);
  wire stream_err = compl.stream_cmd && compl.continuous &&
                    (err_masked != `BYTE_ZERO);
  // Error bit follows the error byte unless the stream path took it
  wire err_bit = (err_masked != `BYTE_ZERO) && !stream_err;
  wire sense_avail = feat.sense_sup && feat.sense_en && compl.sense_data;
  wire [7:0] status_fld = {busy_in,
                           ready_reg && !any_err,
                           fault_reg || stream_err,
                           1'b0,
                           xfer_req_in,
                           align_err,
                           sense_avail,
                           err_bit};
  // Fault handling at command arrival
  wire sense_cmd = host_acc.wdata == `OP_SENSE_EXT;
  wire sense_ok = sense_cmd && feat.sense_sup && feat.fault_sense_sup;
  wire fault_hit = cmd_wr && fault_reg;

  // ************************************************************
  // Pin synchroniser for the index sensor
  // ************************************************************
  // Second stage only feeds the edge detector
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idx_meta_reg <= 1'b0;
      idx_sync_reg <= 1'b0;
      idx_prev_reg <= 1'b0;
    end else begin
      idx_meta_reg <= index_sense;
      idx_sync_reg <= idx_meta_reg;
      idx_prev_reg <= idx_sync_reg;
    end
  end

  // ************************************************************
  // Starting-sector register, two deep
  // ************************************************************
  // Host writes push the old byte down, completion reloads the current byte and, for 48-bit commands only, the previous one
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sect_cur_reg <= `BYTE_ZERO;
      sect_prev_reg <= `BYTE_ZERO;
    end else if (compl.done) begin
      sect_cur_reg <= compl.cur_lba[`LBA_BYTE0];
      if (compl.is_48bit) begin
        sect_prev_reg <= compl.cur_lba[`LBA_BYTE3];
      end
    end else if (sect_wr) begin
      sect_prev_reg <= sect_cur_reg;
      sect_cur_reg <= host_acc.wdata;
    end
  end

  // ************************************************************
  // Ready, failed and error-hold flags
  // ************************************************************
  // An error arriving with the acknowledging read is kept
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ready_reg <= 1'b0;
      err_hold_reg <= 1'b0;
      fail_reg <= 1'b0;
      err_byte_reg <= `BYTE_ZERO;
    end else begin
      if (any_err) begin
        err_hold_reg <= 1'b1;
      end else if (ack_rd) begin
        err_hold_reg <= 1'b0;
      end
      ready_reg <= power_ready && !any_err &&
                   !(err_hold_reg && !ack_rd);
      if (any_err) begin
        fail_reg <= !stream_err;
      end else if (cmd_wr) begin
        fail_reg <= 1'b0;
      end
      if (compl.done) begin
        err_byte_reg <= err_masked;
      end
    end
  end

  // ************************************************************
  // Seek settled flag
  // ************************************************************
  // Displayed copy freezes after an error until status is read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      seek_live_reg <= 1'b0;
      seek_shown_reg <= 1'b0;
    end else begin
      if (seek_start) begin
        seek_live_reg <= 1'b0;
      end else if (seek_settled || low_power_mode) begin
        seek_live_reg <= 1'b1;
      end
      if (!err_hold_reg || ack_rd) begin
        seek_shown_reg <= seek_live_reg;
      end
    end
  end

  // ************************************************************
  // Interrupt pending and sticky fault
  // ************************************************************
  // Completion wins over a same-cycle acknowledge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      intr_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      if (compl.done || fault_hit) begin
        intr_reg <= 1'b1;
      end else if (status_rd) begin
        intr_reg <= 1'b0;
      end
      if (fault_detect) begin
        fault_reg <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Command arrival and fault responses
  // ************************************************************
  // Commands arriving under fault never reach the engine as cmd_written
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_wr_reg <= 1'b0;
      opcode_reg <= `BYTE_ZERO;
      fault_abort_reg <= 1'b0;
      sense_hw_reg <= 1'b0;
    end else begin
      cmd_wr_reg <= cmd_wr && !fault_reg;
      if (cmd_wr) begin
        opcode_reg <= host_acc.wdata;
      end
      fault_abort_reg <= fault_hit && !sense_ok;
      sense_hw_reg <= fault_hit && sense_ok;
    end
  end

  // ************************************************************
  // Output fields and logs at completion
  // ************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fields_reg <= '0;
      mis_log_reg <= 1'b0;
      stream_log_reg <= 1'b0;
      stream_dir_reg <= 1'b0;
    end else begin
      if (compl.done) begin
        fields_reg.status_field <= status_fld;
        fields_reg.error_field <= err_masked;
        fields_reg.lba_field <= stream_err ? compl.first_bad_lba :
                                compl.cur_lba;
        fields_reg.count_field <= stream_err ? compl.bad_count :
                                  `COUNT_ZERO;
      end else if (fault_hit) begin
        fields_reg.status_field <= status_fld;
      end
      // Misalignment is logged even when another error hides it
      mis_log_reg <= compl.done && compl.write_cmd &&
                     compl.misaligned && misalign_log_space;
      stream_log_reg <= compl.done && stream_err;
      if (compl.done && stream_err) begin
        stream_dir_reg <= compl.write_cmd;
      end
    end
  end

  // ************************************************************
  // Register read port
  // ************************************************************
  // Read data is registered: answer one cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data_reg <= `BYTE_ZERO;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= host_acc.rd;
      if (host_acc.rd) begin
        rd_data_reg <= rd_mux;
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
  assign cmd_written = cmd_wr_reg;
  assign cmd_opcode = opcode_reg;
  assign out_fields = fields_reg;
  assign intr_pending = intr_reg;
  assign misalign_log_wr = mis_log_reg;
  assign stream_log_wr = stream_log_reg;
  assign stream_log_is_write = stream_dir_reg;
  assign fault_abort = fault_abort_reg;
  assign sense_hw_error = sense_hw_reg;

endmodule
`default_nettype wire

// >>> bench/ata_status_chk.sv
// Port-level assertions for the status reporting block
`timescale 1ns/100ps
`default_nettype none
`include "ata_status_consts.svh"
module ata_status_chk (
  input wire logic clk,
  input wire logic reset,
  input wire ata_status_pkg::host_access_t host_acc,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic cmd_written,
  input wire logic busy_in,
  input wire ata_status_pkg::completion_t compl,
  input wire ata_status_pkg::output_fields_t out_fields,
  input wire logic intr_pending,
  input wire logic stream_log_wr,
  input wire logic fault_abort,
  input wire logic sense_hw_error
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Continuous stream command ending with an error outside bits 1, 3 and 5
  sequence s_strm;
    compl.done && compl.stream_cmd && compl.continuous &&
      |(compl.err_bits & 8'hd5);
  endsequence
  // Idle-time status read, no completion racing the acknowledge
  sequence s_stat_rd;
    host_acc.rd && host_acc.sel == `SEL_STATUS && !busy_in && !compl.done;
  endsequence
  property p_rd_ans; host_acc.rd |=> rd_valid; endproperty
  property p_rd_only; rd_valid |-> $past(host_acc.rd); endproperty
  property p_busy_rd; host_acc.rd && busy_in |=> rd_data[7]; endproperty
  property p_fixed;
    host_acc.rd && host_acc.sel == `SEL_STATUS |=> !rd_data[5] && !rd_data[2];
  endproperty
  property p_ack; s_stat_rd |=> !intr_pending; endproperty
  property p_intr; compl.done |=> intr_pending; endproperty
  property p_efield;
    compl.done |=> out_fields.error_field == ($past(compl.err_bits) & 8'hd7);
  endproperty
  // Continuous stream completions are left out: their error bit is cleared
  property p_errbit;
    compl.done && !(compl.stream_cmd && compl.continuous) |=>
      out_fields.status_field[0] == |($past(compl.err_bits) & 8'hd7);
  endproperty
  property p_strm;
    s_strm |=> out_fields.status_field[5] && !out_fields.status_field[0]
      && stream_log_wr && out_fields.lba_field == $past(compl.first_bad_lba);
  endproperty
  property p_cmd;
    host_acc.wr && host_acc.sel == `SEL_STATUS && !busy_in |=>
      (cmd_written || fault_abort || sense_hw_error);
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
  a_rd_only: assert property (p_rd_only) else $error("stray read");
  a_busy_rd: assert property (p_busy_rd) else $error("busy read");
  a_fixed: assert property (p_fixed) else $error("fixed bits set");
  a_ack: assert property (p_ack) else $error("no acknowledge");
  a_intr: assert property (p_intr) else $error("no interrupt");
  a_efield: assert property (p_efield) else $error("error byte");
  a_errbit: assert property (p_errbit) else $error("error bit");
  a_strm: assert property (p_strm) else $error("stream error");
  a_cmd: assert property (p_cmd) else $error("command lost");
endmodule
`default_nettype wire

// >>> bench/host_model.sv
// Host adapter model issuing shadow register accesses
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic clk,
  input wire logic busy_in,
  input wire logic xfer_req_in,
  output ata_status_pkg::host_access_t host_acc
);
  // ****************
  // Access driver
  // ****************
  initial host_acc = '0;
  // One strobe cycle; a busy access only when bz asks for it
  task automatic acc(input logic r, input logic w, input logic [2:0] s,
                     input logic h, input logic [7:0] d, input logic bz);
    int n;
    n = 0;
    while (((busy_in && !bz) || (w && xfer_req_in)) && n < 100) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    #1 host_acc = '{r, w, s, h, d};
    @(posedge clk);
    #1 host_acc = '0;
  endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Testbench of the status reporting block
`timescale 1ns/100ps
`default_nettype none
`include "ata_status_consts.svh"
module tb;
  // ****************
  // Bench
  // ****************
  logic clk, reset, busy_in, xfer_req_in, power_ready, cmd_error;
  logic seek_start, seek_settled, low_power_mode, index_sense;
  logic fault_detect, misalign_log_space, rd_valid, cmd_written;
  logic intr_pending, misalign_log_wr, stream_log_wr, stream_log_is_write;
  logic fault_abort, sense_hw_error;
  logic [7:0] rd_data, cmd_opcode;
  logic [63:0] rv;
  logic [7:0] exp_q[$];
  int n_mismatch = 0, checks = 0, cyc = 0;
  ata_status_pkg::host_access_t host_acc;
  ata_status_pkg::completion_t compl, c;
  ata_status_pkg::feature_t feat;
  ata_status_pkg::output_fields_t out_fields;
  host_model i_host (.clk(clk), .busy_in(busy_in),
    .xfer_req_in(xfer_req_in), .host_acc(host_acc));
  ata_status_reporting i_dut (.clk(clk), .reset(reset),
    .host_acc(host_acc), .rd_data(rd_data), .rd_valid(rd_valid),
    .cmd_written(cmd_written), .cmd_opcode(cmd_opcode),
    .busy_in(busy_in), .xfer_req_in(xfer_req_in),
    .power_ready(power_ready), .cmd_error(cmd_error), .compl(compl),
    .feat(feat), .seek_start(seek_start), .seek_settled(seek_settled),
    .low_power_mode(low_power_mode), .index_sense(index_sense),
    .fault_detect(fault_detect), .misalign_log_space(misalign_log_space),
    .out_fields(out_fields), .intr_pending(intr_pending),
    .misalign_log_wr(misalign_log_wr), .stream_log_wr(stream_log_wr),
    .stream_log_is_write(stream_log_is_write), .fault_abort(fault_abort),
    .sense_hw_error(sense_hw_error));
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Note the expected byte, then let the host make the read
  task automatic rd(input logic [2:0] s, input logic h, input logic [7:0] e,
                    input logic bz);
    exp_q.push_back(e);
    i_host.acc(1'b1, 1'b0, s, h, 8'h00, bz);
  endtask
  // Present one completion for a single cycle; fields land next edge
  task automatic fin(input ata_status_pkg::completion_t x);
    x.done = 1'b1;
    @(posedge clk);
    #1 compl = x;
    @(posedge clk);
    #1 compl.done = 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Read answers are taken off the queue mid-cycle, once settled
  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(rd_data, 8'hxx);
      else chk(rd_data, exp_q.pop_front());
    end
  end
  // A hang ends the run as a failure
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(32'hf102));
    {reset, power_ready, misalign_log_space} = 3'h5;
    {busy_in, xfer_req_in, cmd_error, low_power_mode} = 4'h0;
    {seek_start, seek_settled, index_sense, fault_detect} = 4'h0;
    compl = '0;
    feat = '0;
    repeat (4) @(posedge clk);
    #1 reset = 1'b0;
    // Settle by a seek first, then by entering standby; ready comes late
    for (int i = 0; i < 2; i++) begin
      {seek_settled, low_power_mode} = i ? 2'h1 : 2'h2;
      @(posedge clk);
      #1 {seek_settled, low_power_mode} = 2'h0;
      rd(`SEL_STATUS, 1'b0, i ? 8'h50 : 8'h10, 1'b0);
      power_ready = 1'b1;
      seek_start = (i == 0);
      @(posedge clk);
      #1 seek_start = 1'b0;
      if (i == 0) rd(`SEL_STATUS, 1'b0, 8'h40, 1'b0);
    end
    // The read strobe meets the index pulse three edges after the pin
    index_sense = 1'b1;
    @(posedge clk);
    rd(`SEL_STATUS, 1'b0, 8'h52, 1'b0);
    index_sense = 1'b0;
    rv = {$urandom(), $urandom()};
    c = '0;
    c.err_bits = 8'h04;
    c.is_48bit = 1'b1;
    c.cur_lba = rv[47:0];
    fin(c);
    chk(out_fields.status_field, 8'h01);
    chk(intr_pending, 1'b1);
    // Alternate status shows the same byte but leaves the interrupt
    rd(`SEL_ALT_STATUS, 1'b0, 8'h11, 1'b0);
    chk(intr_pending, 1'b1);
    rd(`SEL_ERROR, 1'b0, 8'h04, 1'b0);
    rd(`SEL_SECTOR, 1'b0, rv[7:0], 1'b0);
    rd(`SEL_SECTOR, 1'b1, rv[31:24], 1'b0);
    rd(`SEL_STATUS, 1'b0, 8'h11, 1'b0);
    chk(intr_pending, 1'b0);
    rd(`SEL_STATUS, 1'b0, 8'h51, 1'b0);
    busy_in = 1'b1;
    rd(`SEL_SECTOR, 1'b0, 8'hd1, 1'b1);
    busy_in = 1'b0;
    i_host.acc(1'b0, 1'b1, `SEL_STATUS, 1'b0, 8'h20, 1'b0);
    chk({cmd_written, cmd_opcode}, 9'h120);
    rd(`SEL_STATUS, 1'b0, 8'h50, 1'b0);
    // Alignment codes 0 to 3, then a misaligned write with an error
    feat.lps_sup = 1'b1;
    feat.misalign_sup = 1'b1;
    for (int i = 0; i < 5; i++) begin
      feat.align_rpt = (i == 4) ? 2'h1 : i[1:0];
      c = '0;
      c.write_cmd = 1'b1;
      c.misaligned = 1'b1;
      c.err_bits = (i == 4) ? 8'h10 : 8'h00;
      fin(c);
      chk(out_fields.status_field[2], i == 1 || i == 2);
      if (i == 4) chk(misalign_log_wr, 1'b1);
    end
    // Stream commands, continuous and not
    for (int j = 0; j < 2; j++) begin
      rv = {$urandom(), $urandom()};
      c = '0;
      c.stream_cmd = 1'b1;
      c.continuous = j[0];
      c.write_cmd = j[0];
      c.err_bits = 8'h40;
      c.first_bad_lba = rv[63:16];
      c.bad_count = rv[15:0];
      fin(c);
      chk(out_fields.status_field & 8'h21, j ? 8'h20 : 8'h01);
      if (j) chk({out_fields.lba_field, out_fields.count_field}, rv);
      if (j) chk(stream_log_wr, 1'b1);
      if (j) chk(stream_log_is_write, 1'b1);
    end
    // Sticky fault: plain command aborts, sense command reports
    feat.sense_sup = 1'b1;
    feat.sense_en = 1'b1;
    feat.fault_sense_sup = 1'b1;
    fault_detect = 1'b1;
    @(posedge clk);
    #1 fault_detect = 1'b0;
    i_host.acc(1'b0, 1'b1, `SEL_STATUS, 1'b0, 8'h25, 1'b0);
    chk({cmd_written, fault_abort, out_fields.status_field[5]}, 3'h3);
    i_host.acc(1'b0, 1'b1, `SEL_STATUS, 1'b0, `OP_SENSE_EXT, 1'b0);
    chk({cmd_written, sense_hw_error}, 2'h1);
    fin('0);
    chk(out_fields.status_field[5], 1'b1);
    // Only a power cycle clears the sticky fault
    reset = 1'b1;
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    chk(out_fields.status_field, 8'h00);
    i_host.acc(1'b0, 1'b1, `SEL_STATUS, 1'b0, 8'h20, 1'b0);
    chk({cmd_written, fault_abort}, 2'h2);
    // An engine error drops ready until status is read
    cmd_error = 1'b1;
    xfer_req_in = 1'b1;
    @(posedge clk);
    #1 cmd_error = 1'b0;
    rd(`SEL_STATUS, 1'b0, 8'h09, 1'b0);
    xfer_req_in = 1'b0;
    rd(`SEL_STATUS, 1'b0, 8'h41, 1'b0);
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule
bind ata_status_reporting ata_status_chk i_chk (.clk(clk), .reset(reset),
  .host_acc(host_acc), .rd_data(rd_data), .rd_valid(rd_valid),
  .cmd_written(cmd_written), .busy_in(busy_in), .compl(compl),
  .out_fields(out_fields), .intr_pending(intr_pending),
  .stream_log_wr(stream_log_wr), .fault_abort(fault_abort),
  .sense_hw_error(sense_hw_error));
`default_nettype wire
